// ---- common/clkgen_map.svh ----
// addresses, field positions, reset values and timing counts of the clock generator
`ifndef CLKGEN_MAP_SVH
`define CLKGEN_MAP_SVH

`define CPU_CLOCK_CONTROL_ADDR 16'hFFFB
`define OSC_MODE_SELECT_ADDR 16'hFFF9
`define CPU_CLOCK_CONTROL_RST 8'h04
`define CPU_CLOCK_CONTROL_WMASK 8'h0F
`define CPU_DIV_LSB 0
`define CPU_DIV_MSB 2
`define CLOCK_MODE_BIT 3
`define SCALER_BYPASS_BIT 0
`define SCALER_BYPASS_RST 1'b0
`define CPU_DIV_MAX 3'h4
`define CPU_DIV_SLOWEST 3'h4
`define SWITCH_DELAY_BASE 5'h10
`define OSCILLATOR_MODE_SELECT_STRETCH_CYC 2'h2
`define SCALER_W 8
`define CPU_CLKS_PER_INSTR 2

`endif

// ---- common/clkgen_pkg.sv ----
// types shared by the clock generator modules
package clkgen_pkg;

   typedef enum logic [2:0] {
      OSC_RUN = 3'h1,
      OSC_STOP = 3'h2,
      CPU_HALT = 3'h4
   } power_state_t;

   typedef logic [2:0] cpu_div_t;

endpackage

// ---- rtl/scaler_chain.sv ----
// binary scaler producing divided clock enables from the system clock enable
`timescale 1ns/1ps
`include "clkgen_map.svh"

module scaler_chain
   import clkgen_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic sys_en_i,
   output logic [`SCALER_W-1:0] div_en_o
);

   logic [`SCALER_W-1:0] count_q;
   logic [`SCALER_W-1:0] count_d;

   assign count_d = count_q + {{(`SCALER_W-1){1'b0}}, 1'b1};

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         count_q <= '0;
      end else if (ce_i && sys_en_i) begin
         count_q <= count_d;
      end
   end

   // tap k pulses once every 2^k system clocks; all taps die with sys_en_i
   assign div_en_o[0] = sys_en_i;
   genvar k;
   generate
      for (k = 1; k < `SCALER_W; k = k + 1) begin : g_tap
         assign div_en_o[k] = sys_en_i & (&count_q[k-1:0]);
      end
   endgenerate

endmodule

// ---- rtl/system_clock_divider_control.sv ----
// clock generator: system clock scaler, cpu divider, standby and switchover
//
// Contract
// - oscillator stops on the full-standby instruction or a register stop request
// - reset loads the cpu clock control register with 04H, slowest division
// - divider codes 000 to 100 give system clock over 1,2,4,8,16
// - bypass bit 1 gives oscillator rate, 0 gives half of it
// - upper four control bits read zero and ignore writes
// - shortest instruction lasts two cpu clock periods
// - reset clears bypass bit; its readback is undefined
// - every mode select write stretches the system clock up to two periods
// - bypass change moves cpu and peripheral clocks, not the fixed clock
// - oscillator held stopped during reset pin low; comes up slowest
// - two standby states: oscillator stop and cpu-only halt
// - peripherals get scaler taps and stop with the system clock
// - divider change waits 16,8,4,2,1 instructions of the old setting
`timescale 1ns/1ps
`include "clkgen_map.svh"

module system_clock_divider_control
   import clkgen_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic reset_pin_n_i,
   input wire logic [15:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   input wire logic stop_instr_i,
   input wire logic halt_instr_i,
   input wire logic wake_i,
   output logic osc_run_o,
   output logic sys_clk_en_o,
   output logic cpu_clk_en_o,
   output logic instr_tick_o,
   output logic [`SCALER_W-1:0] periph_clk_en_o,
   output logic fixed_clk_en_o,
   output logic cpu_halted_o,
   output logic [2:0] cpu_div_o
);

   power_state_t state_q;
   power_state_t state_d;
   logic [3:0] ctrl_q;
   cpu_div_t cur_div_q;
   cpu_div_t new_div_q;
   logic switch_pend_q;
   logic [4:0] instr_cnt_q;
   logic bypass_q;
   logic bypass_pend_q;
   logic [1:0] stretch_q;
   logic half_q;
   logic phase_q;
   logic [7:0] rdata_q;

   // the external reset pin acts as a synchronous reset like rst_i
   wire reset_all = rst_i | ~reset_pin_n_i;
   wire ctrl_sel = (addr_i == `CPU_CLOCK_CONTROL_ADDR);
   wire mode_sel = (addr_i == `OSC_MODE_SELECT_ADDR);
   wire ctrl_wr = wr_i & ctrl_sel;
   wire mode_wr = wr_i & mode_sel;
   wire cpu_div_t wr_div = wdata_i[`CPU_DIV_MSB:`CPU_DIV_LSB];
   wire wr_div_legal = (wr_div <= `CPU_DIV_MAX);
   wire reg_stop = ctrl_wr & wdata_i[`CLOCK_MODE_BIT];
   wire stretching = (stretch_q != 2'h0);
   wire stretch_last = (stretch_q == 2'h1);
   wire osc_run = (state_q != OSC_STOP) & ~reset_all;
   wire cpu_run = (state_q == OSC_RUN) & ~reset_all;
   wire [`SCALER_W-1:0] div_en;
   wire sys_en;
   wire cpu_en;
   wire instr_tick;
   wire switch_now;
   wire [4:0] delay_load;

   // the system enable is held low through the stretch window
   assign sys_en = osc_run & ~stretching & (bypass_q | half_q);
   assign cpu_en = cpu_run & div_en[cur_div_q];
   assign instr_tick = cpu_en & phase_q;
   assign delay_load = `SWITCH_DELAY_BASE >> cur_div_q;
   // the divider only moves after a completed instruction, so no runt cpu pulse
   assign switch_now = switch_pend_q & instr_tick & (instr_cnt_q == 5'h01);

   scaler_chain u_scaler (
      .clk_i(clk_i),
      .rst_i(reset_all),
      .ce_i(ce_i),
      .sys_en_i(sys_en),
      .div_en_o(div_en)
   );

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         OSC_RUN: begin
            if (stop_instr_i || reg_stop) begin
               state_d = OSC_STOP;
            end else if (halt_instr_i) begin
               state_d = CPU_HALT;
            end
         end
         OSC_STOP: begin
            if (wake_i) begin
               state_d = OSC_RUN;
            end
         end
         CPU_HALT: begin
            if (wake_i) begin
               state_d = OSC_RUN;
            end
         end
         default: begin
            state_d = OSC_RUN;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (reset_all) begin
         state_q <= OSC_RUN;
      end else if (ce_i) begin
         state_q <= state_d;
      end
   end

   // control register: only the low nibble is storage
   always_ff @(posedge clk_i) begin
      if (reset_all) begin
         ctrl_q <= 4'(`CPU_CLOCK_CONTROL_RST);
      end else if (ce_i) begin
         if (ctrl_wr) begin
            ctrl_q <= 4'(wdata_i & `CPU_CLOCK_CONTROL_WMASK);
         end else if (state_q == OSC_STOP && wake_i) begin
            ctrl_q[`CLOCK_MODE_BIT] <= 1'b0;
         end
      end
   end

   // delayed divider switchover, counted in instructions of the old clock
   always_ff @(posedge clk_i) begin
      if (reset_all) begin
         cur_div_q <= `CPU_DIV_SLOWEST;
         new_div_q <= `CPU_DIV_SLOWEST;
         switch_pend_q <= 1'b0;
         instr_cnt_q <= 5'h00;
      end else if (ce_i) begin
         if (ctrl_wr && wr_div_legal) begin
            new_div_q <= wr_div;
            if (!switch_pend_q) begin
               switch_pend_q <= 1'b1;
               instr_cnt_q <= delay_load;
            end
         end else if (switch_now) begin
            cur_div_q <= new_div_q;
            switch_pend_q <= 1'b0;
         end else if (switch_pend_q && instr_tick) begin
            instr_cnt_q <= instr_cnt_q - 5'h01;
         end
      end
   end

   // oscillator mode select: bypass change applied when the stretch ends
   always_ff @(posedge clk_i) begin
      if (reset_all) begin
         bypass_q <= `SCALER_BYPASS_RST;
         bypass_pend_q <= `SCALER_BYPASS_RST;
         stretch_q <= 2'h0;
      end else if (ce_i) begin
         if (mode_wr) begin
            bypass_pend_q <= wdata_i[`SCALER_BYPASS_BIT];
            stretch_q <= `OSCILLATOR_MODE_SELECT_STRETCH_CYC;
         end else if (stretching) begin
            stretch_q <= stretch_q - 2'h1;
         end
         if (stretch_last && !mode_wr) begin
            bypass_q <= bypass_pend_q;
         end
      end
   end

   // free half-rate phase; the fixed clock ignores bypass and stretch
   always_ff @(posedge clk_i) begin
      if (reset_all) begin
         half_q <= 1'b0;
      end else if (ce_i && osc_run) begin
         half_q <= ~half_q;
      end
   end

   // two cpu clocks make one shortest instruction
   always_ff @(posedge clk_i) begin
      if (reset_all) begin
         phase_q <= 1'b0;
      end else if (ce_i && cpu_en) begin
         phase_q <= ~phase_q;
      end
   end

   // mode select readback is undefined, so it returns zero here
   always_ff @(posedge clk_i) begin
      if (reset_all) begin
         rdata_q <= 8'h00;
      end else if (ce_i && rd_i) begin
         rdata_q <= ctrl_sel ? {4'h0, ctrl_q} : 8'h00;
      end
   end

   assign rdata_o = rdata_q;
   assign osc_run_o = osc_run;
   assign sys_clk_en_o = sys_en & ce_i;
   assign cpu_clk_en_o = cpu_en & ce_i;
   assign instr_tick_o = instr_tick & ce_i;
   assign periph_clk_en_o = div_en & {`SCALER_W{ce_i}};
   assign fixed_clk_en_o = osc_run & half_q & ce_i;
   assign cpu_halted_o = ~cpu_run;
   assign cpu_div_o = cur_div_q;

endmodule

// ---- bench/clkgen_assertions.sv ----
// port checker for the clock generator
`timescale 1ns/1ps
`include "clkgen_map.svh"
module clkgen_checker (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic reset_pin_n_i,
   input wire logic [15:0] addr_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [7:0] rdata_o,
   input wire logic stop_instr_i,
   input wire logic osc_run_o,
   input wire logic sys_clk_en_o,
   input wire logic cpu_clk_en_o,
   input wire logic instr_tick_o,
   input wire logic [`SCALER_W-1:0] periph_clk_en_o,
   input wire logic cpu_halted_o,
   input wire logic [2:0] cpu_div_o
);
   // both reset sources act alike, so one disable covers them
   wire logic rs = rst_i || !reset_pin_n_i;
   default clocking @(posedge clk_i);
   endclocking
   default disable iff (rs);
   // oscillator held through reset, restarts at the first edge after it, slowest divider
   a_reset_slowest: assert property ($fell(rs) |-> cpu_div_o == `CPU_DIV_SLOWEST
      && osc_run_o && !$past(osc_run_o))
      else $error("reset did not restart the oscillator at the slowest divider");
   a_stop_osc: assert property (ce_i && stop_instr_i && osc_run_o && !cpu_halted_o
      |=> !osc_run_o)
      else $error("stop request did not stop the oscillator");
   a_stop_quiet: assert property (!osc_run_o |-> !sys_clk_en_o && periph_clk_en_o == '0)
      else $error("clock enables active while oscillator stopped");
   a_halt_cpu: assert property (cpu_halted_o |-> !cpu_clk_en_o)
      else $error("cpu clock ticked while halted");
   a_div_legal: assert property (cpu_div_o <= 3'h4)
      else $error("active divider code out of range");
   a_tick_cpu: assert property (instr_tick_o |-> cpu_clk_en_o)
      else $error("instruction tick without cpu tick");
   a_cpu_sub: assert property (cpu_clk_en_o |-> sys_clk_en_o)
      else $error("cpu tick off a system clock tick");
   a_oscillator_mode_select_stretch: assert property (ce_i && wr_i && addr_i == `OSC_MODE_SELECT_ADDR
      |=> !sys_clk_en_o [*2])
      else $error("mode select write did not stretch the system clock");
   a_upper_zero: assert property (ce_i && rd_i && addr_i == `CPU_CLOCK_CONTROL_ADDR
      |=> rdata_o[7:4] == 4'h0)
      else $error("control upper bits not zero");
   c_stop: cover property ($fell(osc_run_o));
   c_halt: cover property ($rose(cpu_halted_o));
   c_switch: cover property ($changed(cpu_div_o));
endmodule
bind system_clock_divider_control clkgen_checker u_clkgen_checker (.clk_i, .rst_i, .ce_i,
   .reset_pin_n_i, .addr_i, .wr_i, .rd_i, .rdata_o, .stop_instr_i, .osc_run_o,
   .sys_clk_en_o, .cpu_clk_en_o, .instr_tick_o, .periph_clk_en_o, .cpu_halted_o, .cpu_div_o);

// ---- bench/tb.sv ----
// self-checking bench for the clock generator
`timescale 1ns/1ps
`include "clkgen_map.svh"
module tb;
   logic clk_i = 0, rst_i = 1, ce_i = 1, pin_n = 1, wr_i = 0, rd_i = 0;
   logic [15:0] addr_i = 0;
   logic [7:0] wdata_i = 0, rdata_o;
   logic stop_i = 0, halt_i = 0, wake_i = 0;
   logic osc_o, sys_o, cpu_o, tick_o, fix_o, hlt_o;
   logic [`SCALER_W-1:0] per_o;
   logic [2:0] div_o;
   int seed = 98690, n_errors = 0, cmp_count = 0, cyc = 0;
   wire [3:0] mon = {tick_o, fix_o, cpu_o, sys_o};
   always #10 clk_i = ~clk_i;
   system_clock_divider_control u_system_clock_divider_control (.clk_i(clk_i), .rst_i(rst_i),
      .ce_i(ce_i), .reset_pin_n_i(pin_n), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
      .rd_i(rd_i), .rdata_o(rdata_o), .stop_instr_i(stop_i), .halt_instr_i(halt_i),
      .wake_i(wake_i), .osc_run_o(osc_o), .sys_clk_en_o(sys_o), .cpu_clk_en_o(cpu_o),
      .instr_tick_o(tick_o), .periph_clk_en_o(per_o), .fixed_clk_en_o(fix_o),
      .cpu_halted_o(hlt_o), .cpu_div_o(div_o));
   task end_sim();
      $display("checks %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 60000) begin
         n_errors++;
         end_sim();
      end
   end
   task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      cmp_count++;
      if (g !== e)
         $display("Error %s expected %h seen %h", nm, e, g);
      if (g !== e)
         n_errors++;
   endtask
   task wr(input logic [15:0] a, input logic [7:0] d);
      @(negedge clk_i);
      addr_i = a;
      wdata_i = d;
      wr_i = 1;
      @(negedge clk_i);
      wr_i = 0;
   endtask
   task rd(input logic [15:0] a, input logic [7:0] e, input string nm);
      @(negedge clk_i);
      addr_i = a;
      rd_i = 1;
      @(negedge clk_i);
      rd_i = 0;
      chk(nm, e, rdata_o);
   endtask
   task pls(input logic [2:0] v);
      @(negedge clk_i);
      {stop_i, halt_i, wake_i} = v;
      @(negedge clk_i);
      {stop_i, halt_i, wake_i} = 3'h0;
      @(negedge clk_i);
   endtask
   // cycles from one pulse of the watched enable to the next
   task period(input int k, output int n);
      n = 0;
      for (int i = 0; i < 99 && mon[k] !== 1'b1; i++)
         @(negedge clk_i);
      do begin
         @(negedge clk_i);
         n++;
      end while (mon[k] !== 1'b1 && n < 99);
   endtask
   function int cpu_per(input logic [2:0] c, input logic b);
      return (b ? 1 : 2) << c;
   endfunction
   initial begin
      int p, t;
      logic [2:0] c, o;
      logic b;
      logic [7:0] d;
      repeat (6) @(negedge clk_i);
      rst_i = 0;
      rd(16'hFFFB, 8'h04, "ctrl");
      period(1, p);
      chk("cpu period", cpu_per(3'h4, 0), p);
      o = 3'h4;
      for (int j = 0; j < 7; j++) begin
         c = (j == 0) ? 3'h0 : 3'($unsigned($random(seed)) % 5);
         if (c == o)
            c = 3'((o + 1) % 5);
         b = $random(seed);
         wr(16'hFFF9, {7'($random(seed)), b});
         d = {4'($random(seed)), 1'b0, c};
         wr(16'hFFFB, d);
         t = 0;
         for (int i = 0; i < 2000 && div_o !== c; i++) begin
            t += tick_o;
            @(negedge clk_i);
         end
         chk("switch ticks", 8'(16 >> o), 8'(t));
         rd(16'hFFFB, {4'h0, d[3:0]}, "ctrl");
         period(1, p);
         chk("cpu period", cpu_per(c, b), p);
         period(3, p);
         chk("instr period", 2 * cpu_per(c, b), p);
         period(0, p);
         chk("sys period", b ? 1 : 2, p);
         period(2, p);
         chk("fixed period", 2, p);
         o = c;
      end
      $display("test divider done");
      d = {4'h0, 1'b0, 3'(5 + $unsigned($random(seed)) % 3)};
      wr(16'hFFFB, d);
      repeat (40) @(negedge clk_i);
      chk("div kept", o, div_o);
      rd(16'hFFFB, d, "ctrl");
      rd(16'hFFFA, 8'h00, "unmapped");
      $display("test refused done");
      pls(3'h4);
      chk("osc", 0, osc_o);
      chk("periph", 0, per_o);
      pls(3'h1);
      chk("osc", 1, osc_o);
      wr(16'hFFFB, {5'h01, o});
      chk("osc", 0, osc_o);
      pls(3'h1);
      rd(16'hFFFB, {5'h00, o}, "ctrl");
      pls(3'h2);
      chk("halted", 1, hlt_o);
      chk("cpu", 0, cpu_o);
      period(0, p);
      // a cpu-only halt leaves the system clock at the last bypass setting
      chk("sys period", b ? 1 : 2, p);
      pls(3'h1);
      chk("halted", 0, hlt_o);
      $display("test standby done");
      pin_n = 0;
      @(negedge clk_i);
      chk("osc", 0, osc_o);
      pin_n = 1;
      repeat (2) @(negedge clk_i);
      chk("div", 4, div_o);
      period(0, p);
      chk("sys period", 2, p);
      $display("test reset pin done");
      // a low clock enable must silence every enable output and freeze the state
      @(negedge clk_i);
      ce_i = 0;
      repeat (3) @(negedge clk_i);
      chk("frozen sys", 0, sys_o);
      chk("frozen cpu", 0, cpu_o);
      chk("frozen periph", 0, per_o);
      chk("frozen fixed", 0, fix_o);
      chk("frozen div", 4, div_o);
      ce_i = 1;
      period(0, p);
      chk("sys period", 2, p);
      $display("test clock enable done");
      end_sim();
   end
endmodule
